// *** common/lwrm_pkg.sv ***
// package for the lane width and reversal map
// assumes one 40 MHz core clock; no software registers
package lwrm_pkg;

	// ********************************
	// sizes
	// ********************************
	localparam int unsigned LANES = 8;
	localparam int unsigned LNW = 3;
	localparam logic [LNW-1:0] LANE_MAX = 3'h7;
	localparam logic [LNW-1:0] LANE_NONE = 3'h0;

	// ********************************
	// link widths, one-hot lane counts, and WID_RST as zero for no link
	// ********************************
	localparam logic [3:0] WID_X1 = 4'h1;
	localparam logic [3:0] WID_X2 = 4'h2;
	localparam logic [3:0] WID_X4 = 4'h4;
	localparam logic [3:0] WID_X8 = 4'h8;
	localparam logic [3:0] WID_RST = 4'h0;

	// ********************************
	// core configuration
	// ********************************
	localparam logic CFG_X4 = 1'b0;
	localparam logic CFG_X8 = 1'b1;

	typedef enum logic [1:0] {
		LWRM_IDLE = 2'b00,
		LWRM_TRAIN = 2'b01,
		LWRM_UP = 2'b11
	} lwrm_state_t;

	typedef struct packed {
		logic [3:0] width;
		logic reversed;
		logic up;
	} lwrm_status_t;

	typedef struct packed {
		logic [LANES-1:0] valid;
		logic [LANES*LNW-1:0] partner;
	} lwrm_map_t;

endpackage

// *** rtl/lwrm_lane_map.sv ***
// one lane of the mapping: physical lane index for a logical lane
// assumes width and reversal come from the settled training result
`timescale 1ns/100ps
module lwrm_lane_map #(
	parameter logic [2:0] LOGICAL = 3'h0
) (
	input wire logic [3:0] width,
	input wire logic reversed,
	input wire logic core_x8,
	output logic valid,
	output logic [2:0] phys
);
	logic [3:0] core_w;
	logic [3:0] top;

	always_comb
	begin
		core_w = core_x8 ? lwrm_pkg::WID_X8 : lwrm_pkg::WID_X4;
		top = core_w - 4'h1;
		valid = ({1'b0, LOGICAL} < width);
		if (!valid)
			phys = lwrm_pkg::LANE_NONE;
		else if (reversed)
			phys = top[2:0] - LOGICAL;
		else
			phys = LOGICAL;
	end
endmodule

// *** rtl/lwrm_top.sv ***
// top of the lane width and reversal map
// assumes training inputs are synchronous to clk; rst_n may be asynchronous
//
// Summary of operation
// - four-lane core trains and runs with one, two or four partner lanes.
// - eight-lane core trains and runs with one, two, four or eight partner lanes.
// - lane numbering may be mirrored in every supported configuration.
// - unreversed, logical lane n sits on physical lane n.
// - reversed full x8, core lane i pairs with partner lane seven minus i.
`timescale 1ns/100ps
module lwrm_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic core_x8,
	input wire logic train_start,
	input wire logic train_done,
	input wire logic [7:0] lanes_detected,
	input wire logic [2:0] partner_lane0,
	output lwrm_pkg::lwrm_status_t status,
	output lwrm_pkg::lwrm_map_t lane_map
);
	// ********************************
	// reset release
	// ********************************
	logic rst_s1_q;
	logic rst_s2_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// ********************************
	// width negotiation
	// ********************************
	// highest physical lane the core owns
	function automatic logic [2:0] core_top(
		input logic x8
	);
		logic [3:0] w;
		w = x8 ? lwrm_pkg::WID_X8 : lwrm_pkg::WID_X4;
		return 3'(w - 4'h1);
	endfunction

	// lanes the core owns, as a mask
	function automatic logic [7:0] core_mask(
		input logic x8
	);
		return x8 ? 8'hff : 8'h0f;
	endfunction

	// presence bits mirrored across the lanes the core owns
	function automatic logic [7:0] mirror(
		input logic [7:0] det,
		input logic x8
	);
		logic [7:0] m;
		int top;
		m = '0;
		top = int'(core_top(x8));
		for (int i = 0; i < lwrm_pkg::LANES; i++)
		begin
			if (i <= top)
				m[i] = det[top-i];
		end
		return m;
	endfunction

	// ********************************
	// width and direction
	// ********************************
	// widest link with all lanes present, counted from partner lane 0
	function automatic logic [3:0] pick_width(
		input logic [7:0] det,
		input logic x8,
		input logic rev
	);
		logic [3:0] w;
		logic [7:0] n;
		w = lwrm_pkg::WID_RST;
		n = rev ? mirror(det, x8) : det;
		if (x8 && (&n))
			w = lwrm_pkg::WID_X8;
		else if (&n[3:0])
			w = lwrm_pkg::WID_X4;
		else if (&n[1:0])
			w = lwrm_pkg::WID_X2;
		else if (n[0])
			w = lwrm_pkg::WID_X1;
		return w;
	endfunction

	// reversed when partner lane 0 lands on our top owned lane
	function automatic logic want_rev(
		input logic [2:0] p0,
		input logic x8
	);
		return p0 != lwrm_pkg::LANE_NONE && p0 == core_top(x8);
	endfunction

	// ********************************
	// training result
	// ********************************
	logic [3:0] width_w;
	logic rev_w;
	assign rev_w = want_rev(partner_lane0, core_x8);
	assign width_w = pick_width(lanes_detected, core_x8, rev_w);

	// ********************************
	// training state
	// ********************************
	lwrm_pkg::lwrm_state_t state_q;
	lwrm_pkg::lwrm_state_t state_d;
	logic [3:0] width_q;
	logic rev_q;
	logic cfg_q;
	logic up_q;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			lwrm_pkg::LWRM_IDLE:
				if (train_start)
					state_d = lwrm_pkg::LWRM_TRAIN;
			lwrm_pkg::LWRM_TRAIN:
				if (train_done && width_w != lwrm_pkg::WID_RST)
					state_d = lwrm_pkg::LWRM_UP;
			lwrm_pkg::LWRM_UP:
				if (train_start)
					state_d = lwrm_pkg::LWRM_TRAIN;
			default:
				state_d = lwrm_pkg::LWRM_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_s2_q)
	begin
		if (!rst_s2_q)
			state_q <= lwrm_pkg::LWRM_IDLE;
		else
			state_q <= state_d;
	end

	// ********************************
	// link-up flag
	// ********************************
	always_ff @(posedge clk or negedge rst_s2_q)
	begin
		if (!rst_s2_q)
			up_q <= 1'b0;
		else
			up_q <= (state_d == lwrm_pkg::LWRM_UP);
	end

	// ********************************
	// result and core size, held until retraining
	// ********************************
	always_ff @(posedge clk or negedge rst_s2_q)
	begin
		if (!rst_s2_q)
		begin
			width_q <= lwrm_pkg::WID_RST;
			rev_q <= 1'b0;
			cfg_q <= lwrm_pkg::CFG_X4;
		end
		else if (state_q == lwrm_pkg::LWRM_TRAIN && train_done)
		begin
			width_q <= width_w;
			rev_q <= rev_w;
			cfg_q <= core_x8;
		end
	end

	// ********************************
	// per-lane mapping
	// ********************************
	logic [7:0] valid_w;
	logic [23:0] phys_w;
	genvar g;
	generate
		for (g = 0; g < lwrm_pkg::LANES; g++)
		begin : g_lane
			lwrm_lane_map #(.LOGICAL(3'(g))) u_map (
				.width(width_q),
				.reversed(rev_q),
				.core_x8(cfg_q),
				.valid(valid_w[g]),
				.phys(phys_w[g*3 +: 3])
			);
		end
	endgenerate

	logic [7:0] mask_w;
	assign mask_w = core_mask(cfg_q);

	lwrm_pkg::lwrm_map_t map_q;
	always_ff @(posedge clk or negedge rst_s2_q)
	begin
		if (!rst_s2_q)
			map_q <= '0;
		else if (state_q == lwrm_pkg::LWRM_UP)
		begin
			map_q.valid <= valid_w & mask_w;
			map_q.partner <= phys_w;
		end
		else
			map_q <= '0;
	end

	// ********************************
	// outputs
	// ********************************
	assign lane_map = map_q;
	assign status.width = width_q;
	assign status.reversed = rev_q;
	assign status.up = up_q;
endmodule

// *** tb/lwrm_sva.sv ***
// checker on the lane map top ports
// assumes bind onto lwrm_top
`timescale 1ns/100ps
module lwrm_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic core_x8,
	input wire logic train_done,
	input wire logic [7:0] lanes_detected,
	input lwrm_pkg::lwrm_status_t status,
	input lwrm_pkg::lwrm_map_t lane_map
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence settled;
		status.up && $past(status.up);
	endsequence
	up_cause_a: assert property ($rose(status.up) |-> $past(train_done)) else $error("up");
	map_hold_a: assert property (settled |=> $stable(lane_map) || !status.up) else $error("hold");
	x4_width_a: assert property (!core_x8 |-> status.width != 4'h8) else $error("x4");
	x8_full_a: assert property ($rose(status.up) && status.width == 4'h8
		|-> $past(lanes_detected) == 8'hff) else $error("x8");
	ident_map_a: assert property (settled ##0 !status.reversed && lane_map.valid[1]
		|-> lane_map.partner[5:3] == 3'h1) else $error("ident");
	rev_map_a: assert property (settled ##0 status.reversed && core_x8
		|-> lane_map.partner[2:0] == 3'h7) else $error("rev");
endmodule
bind lwrm_top lwrm_sva i_sva (.clk, .rst_n, .core_x8, .train_done, .lanes_detected, .status,
	.lane_map);

// *** tb/lwrm_partner.sv ***
// far-side lane presence model
// assumes width and reversal picked by the bench
`timescale 1ns/100ps
module lwrm_partner (
	input wire logic [3:0] width,
	input wire logic rev,
	input wire logic core_x8,
	output logic [7:0] lanes_detected,
	output logic [2:0] partner_lane0
);
	logic [7:0] low;
	logic [7:0] flip;
	assign low = 8'hff >> (4'h8 - width);
	always_comb
	begin
		flip = '0;
		for (int i = 0; i < 8; i++)
		begin
			if (core_x8)
				flip[i] = low[7-i];
			else if (i < 4)
				flip[i] = low[3-i];
		end
	end
	assign lanes_detected = rev ? flip : low;
	assign partner_lane0 = !rev ? 3'h0 : core_x8 ? 3'h7 : 3'h3;
endmodule

// *** tb/lwrm_top_tb_top.sv ***
// bench for the lane width and reversal map
// assumes the partner model drives lane presence
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("BAD %0t got %h", $time, a); end end
module lwrm_top_tb_top;
	logic clk, rst_n, core_x8, train_start, train_done, rev;
	logic [3:0] pw;
	logic [7:0] lanes_detected;
	logic [2:0] partner_lane0;
	lwrm_pkg::lwrm_status_t status;
	lwrm_pkg::lwrm_map_t lane_map;
	int fails = 0, n_compared = 0, cyc = 0;
	lwrm_top i_dut (.clk, .rst_n, .core_x8, .train_start, .train_done, .lanes_detected,
		.partner_lane0, .status, .lane_map);
	lwrm_partner i_far (.width(pw), .rev, .core_x8, .lanes_detected, .partner_lane0);
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fails++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("compared %0d bad %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic link(input logic x8, input logic [3:0] w, input logic r);
		@(negedge clk);
		train_start = 1;
		@(negedge clk);
		train_start = 0;
		core_x8 = x8;
		pw = w;
		rev = r;
		train_done = 1;
		@(negedge clk);
		train_done = 0;
		repeat (2) @(negedge clk);
		`CHK(status, {w, r, 1'b1})
		for (int i = 0; i < 8; i++)
		begin
			`CHK(lane_map.valid[i], 1'(i < w))
			if (i < w)
				`CHK(lane_map.partner[i*3+:3], 3'(r ? (x8 ? 7 : 3) - i : i))
		end
	endtask
	task automatic t_widths(input logic x8);
		for (int k = 0; k < (x8 ? 8 : 6); k++)
			link(x8, 4'h1 << (k / 2), k[0]);
		$display("widths done");
	endtask
	task automatic t_hold();
		link(1'b1, 4'h8, 1'b1);
		pw = 4'h1;
		repeat (4) @(negedge clk);
		`CHK(status.width, 4'h8)
		`CHK(lane_map.partner[2:0], 3'h7)
		$display("hold done");
	endtask
	task automatic t_refuse();
		@(negedge clk);
		train_start = 1;
		@(negedge clk);
		train_start = 0;
		core_x8 = 0;
		pw = 4'h0;
		rev = 0;
		train_done = 1;
		@(negedge clk);
		train_done = 0;
		repeat (2) @(negedge clk);
		`CHK(status, 6'h00)
		`CHK(lane_map.valid, 8'h00)
		pw = 4'h8;
		train_done = 1;
		@(negedge clk);
		train_done = 0;
		repeat (2) @(negedge clk);
		`CHK(status, {4'h4, 1'b0, 1'b1})
		`CHK(lane_map.valid, 8'h0f)
		$display("refuse done");
	endtask
	initial
	begin
		rst_n = 0;
		core_x8 = 0;
		train_start = 0;
		train_done = 0;
		pw = 0;
		rev = 0;
		repeat (12) @(negedge clk);
		rst_n = 1;
		repeat (3) @(negedge clk);
		t_widths(1'b0);
		t_refuse();
		t_widths(1'b1);
		t_hold();
		end_sim();
	end
endmodule
